// [async_serial_pkg.sv]
// Shared constants and types for the asynchronous serial adapter core
package async_serial_pkg;
    // Register map: one pair per aligned word
    localparam logic [11:0] CTRL_STATUS_OFFSET = 12'h000;
    localparam logic [11:0] DATA_OFFSET        = 12'h004;
    localparam int          PAIR_SEL_BIT       = 2;

    // Control register fields
    localparam int CR_DIV_LSB  = 0;
    localparam int CR_WORD_LSB = 2;
    localparam int CR_RTS_LO   = 5;
    localparam int CR_RTS_HI   = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Divide field codes
    localparam logic [1:0] DIV_ONE    = 2'h0;
    localparam logic [1:0] DIV_16     = 2'h1;
    localparam logic [1:0] DIV_64     = 2'h2;
    localparam logic [1:0] DIV_MRESET = 2'h3;

    // Clock edges per bit minus one, and half a bit minus one
    localparam logic [5:0] DIV1_LAST  = 6'h00;
    localparam logic [5:0] DIV16_LAST = 6'h0F;
    localparam logic [5:0] DIV64_LAST = 6'h3F;
    localparam logic [5:0] DIV16_HALF = 6'h07;
    localparam logic [5:0] DIV64_HALF = 6'h1F;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic eight;
        logic parOn;
        logic parOdd;
        logic twoStop;
    } format_type;

    typedef struct packed {
        logic irq;
        logic parErr;
        logic overrun;
        logic frameErr;
        logic cts;
        logic dcd;
        logic txEmpty;
        logic rxFull;
    } status_type;
endpackage

// [async_serial_adapter_core.sv]
// Asynchronous serial adapter core with an AXI4-Lite register slave
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module async_serial_adapter_core #(
    parameter int ADDR_W = 12
) (
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output      logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output      logic              wready,
    output      logic [1:0]        bresp,
    output      logic              bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output      logic              arready,
    output      logic [31:0]       rdata,
    output      logic [1:0]        rresp,
    output      logic              rvalid,
    input  wire logic              rready,
    // Serial link and modem lines
    input  wire logic              txClk,
    output      logic              txData,
    input  wire logic              rxClk,
    input  wire logic              rxData,
    input  wire logic              cts,
    input  wire logic              dcd,
    output      logic              rtsN
);
    if (ADDR_W < 12) begin : g_addr_check
        $error("ADDR_W must be at least 12");
    end

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_type;
    typedef enum logic [2:0] {RX_IDLE, RX_HUNT, RX_DATA, RX_PARITY, RX_STOP} rx_state_type;

    // Returns {mapped, pair select}
    function automatic logic [1:0] decodeAddr(input logic [ADDR_W-1:0] a);
        logic [11:0] low;
        low = a[11:0];
        decodeAddr = 2'h0;
        // Shift, not a slice: no empty upper range when ADDR_W is 12
        if ((a >> 12) == '0 && low == async_serial_pkg::CTRL_STATUS_OFFSET) begin
            decodeAddr = 2'h2;
        end else if ((a >> 12) == '0 && low == async_serial_pkg::DATA_OFFSET) begin
            decodeAddr = 2'h3;
        end
    endfunction

    function automatic async_serial_pkg::format_type decodeFormat(input logic [2:0] w);
        decodeFormat.eight   = w[2];
        decodeFormat.parOn   = !(w[2] && !w[1]);
        decodeFormat.parOdd  = w[0] && !(w[2] && !w[1]);
        decodeFormat.twoStop = (!w[2] && !w[1]) || (w == 3'h4);
    endfunction

    function automatic logic [5:0] lastCount(input logic [1:0] d);
        unique case (d)
            async_serial_pkg::DIV_16: lastCount = async_serial_pkg::DIV16_LAST;
            async_serial_pkg::DIV_64: lastCount = async_serial_pkg::DIV64_LAST;
            default:                  lastCount = async_serial_pkg::DIV1_LAST;
        endcase
    endfunction

    // Control and mode state
    logic [7:0]                   ctrl;
    logic                         inReset;
    async_serial_pkg::format_type fmt;
    logic [1:0]                   divSel;
    logic [5:0]                   bitLast;
    logic [5:0]                   halfLast;

    // Bus state
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] awAddrQ;
    logic [7:0]        wDataQ;
    logic              wLaneQ;
    logic              doWrite;
    logic [1:0]        wrHit;
    logic [1:0]        rdHit;
    logic              wrCtrl;
    logic              wrTx;
    logic              rdTake;
    logic              rxDataRead;

    // Transmitter
    tx_state_type txState;
    logic         txClkPrev;
    logic         txFall;
    logic [5:0]   txDivCnt;
    logic         txTick;
    logic [7:0]   txHold;
    logic         txHoldFull;
    logic [7:0]   txShift;
    logic [2:0]   txBit;
    logic         txStopLeft;
    logic         txLoad;
    logic         txParity;
    logic [2:0]   lastBit;

    // Receiver
    rx_state_type rxState;
    logic         rxClkPrev;
    logic         rxRise;
    logic [5:0]   rxCnt;
    logic         rxTick;
    logic [7:0]   rxShift;
    logic [2:0]   rxBit;
    logic         rxParBit;
    logic         rxDone;
    logic         rxAccept;
    logic [7:0]   rxHold;
    logic         rxFull;
    logic         overrun;
    logic         frameErr;
    logic         parErr;
    async_serial_pkg::status_type status;

    assign divSel   = ctrl[async_serial_pkg::CR_DIV_LSB +: 2];
    assign fmt      = decodeFormat(ctrl[async_serial_pkg::CR_WORD_LSB +: 3]);
    assign bitLast  = lastCount(divSel);
    assign halfLast = (divSel == async_serial_pkg::DIV_64) ? async_serial_pkg::DIV64_HALF
                                                           : async_serial_pkg::DIV16_HALF;
    assign lastBit  = fmt.eight ? 3'h7 : 3'h6;

    // Write channel: address and data may arrive in either order
    assign awready  = !awHeld && !bvalid;
    assign wready   = !wHeld && !bvalid;
    assign doWrite  = awHeld && wHeld && !bvalid;
    assign wrHit    = decodeAddr(awAddrQ);
    assign wrCtrl   = doWrite && wLaneQ && wrHit == 2'h2;
    assign wrTx     = doWrite && wLaneQ && wrHit == 2'h3;

    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld  <= 1'b0;
            wHeld   <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= async_serial_pkg::RESP_OKAY;
            awAddrQ <= '0;
            wDataQ  <= 8'h00;
            wLaneQ  <= 1'b0;
        end else if (ce) begin
            if (awvalid && awready) begin
                awHeld  <= 1'b1;
                awAddrQ <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld  <= 1'b1;
                wDataQ <= wdata[7:0];
                wLaneQ <= wstrb[0];
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= wrHit[1] ? async_serial_pkg::RESP_OKAY : async_serial_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    assign arready    = !rvalid;
    assign rdTake     = arvalid && arready;
    assign rdHit      = decodeAddr(araddr);
    assign rxDataRead = rdTake && rdHit == 2'h3;
    assign status     = '{irq: 1'b0, parErr: parErr, overrun: overrun, frameErr: frameErr,
                          cts: cts, dcd: dcd, txEmpty: !txHoldFull && !cts && !inReset,
                          rxFull: rxFull};

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= async_serial_pkg::RESP_OKAY;
        end else if (ce) begin
            if (rdTake) begin
                rvalid <= 1'b1;
                rresp  <= rdHit[1] ? async_serial_pkg::RESP_OKAY : async_serial_pkg::RESP_SLVERR;
                unique case (rdHit)
                    2'h2:    rdata <= {24'h000000, status};
                    2'h3:    rdata <= {24'h000000, rxHold};
                    default: rdata <= 32'h0000_0000;
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Control register; power-up leaves the core in reset until programmed
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl    <= async_serial_pkg::CTRL_RESET;
            inReset <= 1'b1;
        end else if (ce && wrCtrl) begin
            ctrl    <= wDataQ;
            inReset <= wDataQ[async_serial_pkg::CR_DIV_LSB +: 2] == async_serial_pkg::DIV_MRESET;
        end
    end

    assign rtsN = !(!ctrl[async_serial_pkg::CR_RTS_HI] ||
                    (ctrl[async_serial_pkg::CR_RTS_LO] && ctrl[async_serial_pkg::CR_RTS_HI]));

    // Transmit clock edge and bit divider
    assign txFall = txClkPrev && !txClk;
    assign txTick = txFall && txDivCnt == bitLast;

    always_ff @(posedge clk) begin
        if (srst) begin
            txClkPrev <= 1'b0;
            txDivCnt  <= 6'h00;
        end else if (ce) begin
            txClkPrev <= txClk;
            if (inReset || txTick) begin
                txDivCnt <= 6'h00;
            end else if (txFall) begin
                txDivCnt <= txDivCnt + 6'h01;
            end
        end
    end

    // Holding register: a write in the load cycle is kept, not lost
    assign txLoad = txTick && txHoldFull && !inReset &&
                    (txState == TX_IDLE || (txState == TX_STOP && !txStopLeft));

    always_ff @(posedge clk) begin
        if (srst) begin
            txHold     <= 8'h00;
            txHoldFull <= 1'b0;
        end else if (ce) begin
            if (inReset) begin
                txHoldFull <= 1'b0;
            end else if (wrTx) begin
                txHold     <= wDataQ;
                txHoldFull <= 1'b1;
            end else if (txLoad) begin
                txHoldFull <= 1'b0;
            end
        end
    end

    assign txParity = ^(txShift & {fmt.eight, 7'h7F}) ^ fmt.parOdd;

    always_ff @(posedge clk) begin
        if (srst) begin
            txState    <= TX_IDLE;
            txData     <= 1'b1;
            txShift    <= 8'h00;
            txBit      <= 3'h0;
            txStopLeft <= 1'b0;
        end else if (ce) begin
            if (inReset) begin
                txState <= TX_IDLE;
                txData  <= 1'b1;
            end else if (txLoad) begin
                txShift <= txHold;
                txState <= TX_START;
                txData  <= 1'b0;
            end else if (txTick) begin
                unique case (txState)
                    TX_IDLE: txData <= 1'b1;
                    TX_START: begin
                        txState <= TX_DATA;
                        txBit   <= 3'h0;
                        txData  <= txShift[0];
                    end
                    TX_DATA: begin
                        if (txBit == lastBit) begin
                            txStopLeft <= fmt.twoStop;
                            txState    <= fmt.parOn ? TX_PARITY : TX_STOP;
                            txData     <= fmt.parOn ? txParity : 1'b1;
                        end else begin
                            txBit  <= txBit + 3'h1;
                            txData <= txShift[txBit + 3'h1];
                        end
                    end
                    TX_PARITY: begin
                        txState <= TX_STOP;
                        txData  <= 1'b1;
                    end
                    TX_STOP: begin
                        if (txStopLeft) begin
                            txStopLeft <= 1'b0;
                        end else begin
                            txState <= TX_IDLE;
                        end
                        txData <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Receiver; carrier loss holds it idle
    assign rxRise   = !rxClkPrev && rxClk;
    assign rxTick   = rxRise && rxCnt == bitLast;
    assign rxDone   = rxTick && rxState == RX_STOP;
    assign rxAccept = rxDone && (!rxFull || rxDataRead);

    always_ff @(posedge clk) begin
        if (srst) begin
            rxClkPrev <= 1'b0;
            rxState   <= RX_IDLE;
            rxCnt     <= 6'h00;
            rxShift   <= 8'h00;
            rxBit     <= 3'h0;
            rxParBit  <= 1'b0;
        end else if (ce) begin
            rxClkPrev <= rxClk;
            if (inReset || dcd) begin
                rxState <= RX_IDLE;
                rxCnt   <= 6'h00;
            end else if (rxRise) begin
                rxCnt <= (rxState == RX_IDLE || rxTick) ? 6'h00 : rxCnt + 6'h01;
                unique case (rxState)
                    RX_IDLE: begin
                        if (!rxData) begin
                            rxShift <= 8'h00;
                            rxBit   <= 3'h0;
                            rxState <= (divSel == async_serial_pkg::DIV_ONE) ? RX_DATA : RX_HUNT;
                            rxCnt   <= (divSel == async_serial_pkg::DIV_ONE) ? 6'h00 : 6'h01;
                        end
                    end
                    RX_HUNT: begin
                        if (rxData) begin
                            rxState <= RX_IDLE;
                        end else if (rxCnt == halfLast) begin
                            rxState <= RX_DATA;
                            rxCnt   <= 6'h00;
                        end
                    end
                    RX_DATA: begin
                        if (rxTick) begin
                            rxShift[rxBit] <= rxData;
                            rxBit          <= rxBit + 3'h1;
                            if (rxBit == lastBit) begin
                                rxState <= fmt.parOn ? RX_PARITY : RX_STOP;
                            end
                        end
                    end
                    RX_PARITY: begin
                        if (rxTick) begin
                            rxParBit <= rxData;
                            rxState  <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rxTick) begin
                            rxState <= RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Receive holding register and error flags; a new character beats a same-cycle read
    always_ff @(posedge clk) begin
        if (srst) begin
            rxHold   <= 8'h00;
            rxFull   <= 1'b0;
            overrun  <= 1'b0;
            frameErr <= 1'b0;
            parErr   <= 1'b0;
        end else if (ce) begin
            if (inReset) begin
                rxFull   <= 1'b0;
                overrun  <= 1'b0;
                frameErr <= 1'b0;
                parErr   <= 1'b0;
            end else if (rxAccept) begin
                rxHold   <= rxShift;
                rxFull   <= 1'b1;
                frameErr <= !rxData;
                parErr   <= fmt.parOn && (^rxShift ^ rxParBit ^ fmt.parOdd);
                overrun  <= 1'b0;
            end else if (rxDone) begin
                overrun <= 1'b1;
            end else if (rxDataRead) begin
                rxFull  <= 1'b0;
                overrun <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence falseStart;
        ce && !inReset && !dcd && rxState == RX_HUNT && rxRise && rxData;
    endsequence

    a_tx_idle_mark:     assert property (txState == TX_IDLE |-> txData)
        else $error("transmit line not at mark while idle");
    a_tx_start_space:   assert property (txState == TX_START |-> !txData)
        else $error("start bit not at space");
    a_tx_parity_bit:    assert property (txState == TX_PARITY |-> txData == txParity)
        else $error("parity bit wrong");
    a_tx_write_full:    assert property (ce && wrTx && !inReset |=> txHoldFull && !status.txEmpty)
        else $error("transmit write did not clear empty");
    a_tx_auto_load:     assert property (ce && txLoad && !wrTx |=> !txHoldFull ##0 txState == TX_START)
        else $error("holding data not moved to shifter");
    a_tx_fall_launch:   assert property ($changed(txData) |-> $past(txFall && ce) || $past(inReset))
        else $error("transmit bit changed off a clock fall");
    a_rx_false_start:   assert property (falseStart |=> rxState == RX_IDLE)
        else $error("false start not rejected");
    a_rx_seven_msb:     assert property (ce && rxAccept && !fmt.eight |=> rxHold[7] == 1'b0)
        else $error("bit seven not cleared in seven bit format");
    a_rx_overrun_flag:  assert property (ce && !inReset && rxDone && rxFull && !rxDataRead |=> overrun)
        else $error("overrun not flagged");
    a_rd_data_value:    assert property (ce && rxDataRead |=> rvalid && rdata[7:0] == $past(rxHold))
        else $error("data read returned wrong character");
    a_reset_held_quiet: assert property (inReset && $past(inReset) && $past(ce) |-> txData && !rxFull)
        else $error("core active while held in reset");
endmodule

// [serial_peer.sv]
// Far-side serial model: free baud clock, loopback line and frame monitor
`timescale 1ns/1ps
module serial_peer (
    // Serial line
    input  wire logic        txData,
    input  wire logic        forceSpace,
    output      logic        lineClk,
    output      logic        rxData,
    // Monitor
    output      logic        busy,
    output      logic [10:0] frame
);
    logic [3:0]  cnt = 4'h0;
    logic [10:0] sh  = 11'h7FF;

    // Modem clock runs free, as a baud source would
    initial begin
        lineClk = 1'b0;
        forever #40 lineClk = ~lineClk;
    end

    // Echo keeps both directions busy; forceSpace pulls the line to space for error cases
    assign rxData = txData && !forceSpace;
    assign busy   = cnt != 4'h0;

    // Sampled on the rise, half a bit after launch
    always @(posedge lineClk) begin
        if (busy || txData === 1'b0) begin
            sh  <= {txData, sh[10:1]};
            cnt <= (cnt == 4'hA) ? 4'h0 : cnt + 4'h1;
            if (cnt == 4'hA) begin
                frame <= {txData, sh[10:1]};
            end
        end
    end
endmodule

// [testbench.sv]
// Self-checking bench for the serial adapter core
`timescale 1ns/1ps
module testbench;
    typedef struct packed {logic [7:0] ctrl; logic [7:0] d; logic [7:0] x;} row_type;
    logic        clk = 1'b0, srst = 1'b1, ce = 1'b1;
    logic        forceSpace = 1'b0, cts = 1'b0, dcd = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid, txData, lineClk, rxData, busy, rtsN;
    logic [1:0]  bresp, rresp, rsp;
    logic [10:0] frame;
    logic [7:0]  v;
    async_serial_pkg::status_type st;
    int          fails = 0, checksDone = 0;
    row_type     rows [10] = '{24'h00A525, 24'h043C3C, 24'h08FF7F, 24'h0C0101, 24'h108080,
                               24'h145A5A, 24'h18C3C3, 24'h1C0000, 24'h159696, 24'h1A6969};

    async_serial_adapter_core async_serial_adapter_core_inst (
        .clk, .srst, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .txClk(lineClk), .txData, .rxClk(lineClk), .rxData, .cts, .dcd, .rtsN
    );
    serial_peer serial_peer_inst (.txData, .forceSpace, .lineClk, .rxData, .busy, .frame);

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [11:0] g, input logic [11:0] e, input string m);
        checksDone++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    // Ready is looked at mid-cycle, where it cannot race the edge
    task automatic axw(input logic [11:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            ta = awready;
            tw = wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask

    task automatic axr(input logic [11:0] a);
        logic ta, tr;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk);
            ta = arready;
            tr = rvalid;
            v = rdata[7:0];
            rsp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
        st = v;
    endtask

    task automatic waitSt(input int b, input int n);
        int i;
        i = 0;
        do begin
            axr(12'h000);
            i++;
        end while (st[b] !== 1'b1 && i < n);
        if (st[b] !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: status wait ran out", $time);
        end
    endtask

    function automatic logic [10:0] expFrame(input logic [2:0] f, input logic [7:0] d);
        logic [10:0] r;
        int          n;
        r = 11'h7FE;
        n = f[2] ? 8 : 7;
        for (int i = 0; i < n; i++) r[i+1] = d[i];
        if (f != 3'h4 && f != 3'h5) r[n+1] = (f[2] ? ^d : ^d[6:0]) ^ f[0];
        return r;
    endfunction

    initial begin
        #300000;
        fails++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            axw(12'h000, 8'h03);
            axw(12'h000, rows[i].ctrl);
            axw(12'h004, rows[i].d);
            waitSt(0, 3000);
            axr(12'h004);
            cmp({4'h0, v}, {4'h0, rows[i].x}, "rx byte");
            if (rows[i].ctrl[1:0] == 2'h0) begin
                for (int k = 0; k < 99 && busy; k++) @(posedge clk);
                cmp({1'b0, frame}, {1'b0, expFrame(rows[i].ctrl[4:2], rows[i].d)}, "frame");
            end
            $display("row %0d done", i);
        end
        axw(12'h000, 8'h03);
        axw(12'h000, 8'h0C);
        forceSpace <= 1'b1;
        waitSt(0, 100);
        forceSpace <= 1'b0;
        cmp({4'h0, st}, 12'h053, "line errors");
        axw(12'h000, 8'h03);
        axw(12'h000, 8'h15);
        forceSpace <= 1'b1;
        repeat (16) @(posedge clk);
        forceSpace <= 1'b0;
        repeat (1500) @(posedge clk);
        axr(12'h000);
        cmp({4'h0, v}, 12'h002, "false start");
        $display("line tests done");
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        axr(12'h000);
        cmp({4'h0, v}, 12'h000, "status in reset");
        cmp({11'h0, txData}, 12'h001, "idle line");
        axr(12'h008);
        cmp({2'h0, rsp, v}, {2'h0, async_serial_pkg::RESP_SLVERR, 8'h00}, "unmapped");
        axw(12'h008, 8'h00);
        cmp({10'h000, rsp}, {10'h000, async_serial_pkg::RESP_SLVERR}, "unmapped write");
        $display("reset and map done");
        axw(12'h000, 8'h03);
        axw(12'h000, 8'h50);
        cmp({10'h000, rsp}, {10'h000, async_serial_pkg::RESP_OKAY}, "write resp");
        cmp({11'h0, rtsN}, 12'h001, "rts");
        axr(12'h000);
        cmp({4'h0, v}, 12'h002, "status read");
        cts <= 1'b1;
        dcd <= 1'b1;
        axr(12'h000);
        cmp({4'h0, v}, 12'h00C, "modem lines");
        cts <= 1'b0;
        dcd <= 1'b0;
        axw(12'h004, 8'h11);
        waitSt(1, 100);
        axw(12'h004, 8'h22);
        axr(12'h000);
        cmp({11'h0, st.txEmpty}, 12'h000, "holding full");
        waitSt(0, 1000);
        axr(12'h004);
        cmp({4'h0, v}, 12'h011, "first byte");
        waitSt(0, 1000);
        axr(12'h004);
        cmp({4'h0, v}, 12'h022, "second byte");
        $display("double buffer done");
        axw(12'h004, 8'h33);
        waitSt(1, 100);
        axw(12'h004, 8'h44);
        waitSt(5, 2000);
        cmp({11'h0, st.overrun}, 12'h001, "overrun");
        axr(12'h004);
        cmp({4'h0, v}, 12'h033, "kept byte");
        $display("overrun done");
        end_sim();
    end
endmodule
